// ---- src/twtcc_top.sv ----
// Command control and transmit sequencing for the two-wire port
`timescale 1ns/1ps
module twtcc_top #(
  parameter int MS_CYCLES =
    twtcc_pkg::TICK_TIME_MS * twtcc_pkg::US_PER_MS * twtcc_pkg::CLK_MHZ,
  parameter int CAL_CYCLES =
    twtcc_pkg::CAL_TIME_US * twtcc_pkg::CLK_MHZ
) (
  // System clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Two-wire link from host
  input wire logic link_clk_in,
  input wire logic link_data_in,
  // Static configuration
  input wire logic start_edge_select_in,
  input wire logic [twtcc_pkg::STOP_SEL_W-1:0] stop_select_in,
  // Core control and status
  output logic core_reset_out,
  output logic cal_busy_out,
  output logic tx_active_out,
  output logic sleep_out,
  output logic two_wire_port_on_out,
  output logic tx_data_out
);

  localparam int MSW = twtcc_pkg::MS_CNT_W;
  localparam int CLW = twtcc_pkg::CAL_CNT_W;
  localparam int SMW = twtcc_pkg::STOP_MS_W;
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);
  localparam logic [CLW-1:0] CAL_LAST = CLW'(CAL_CYCLES - 1);

  // Reset release synchroniser
  logic rst_meta_q;
  logic rst_q;

  // Async assert, release after two edges
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // Link-domain command decoder
  logic reset_tog;
  logic release_tog;
  logic soft_tog;

  // Link clock may stop between frames; toggles hold
  twtcc_shifter u_shifter (
    .link_clk_in(link_clk_in),
    .rst_n_in(rst_q),
    .data_in(link_data_in),
    .reset_tog_out(reset_tog),
    .release_tog_out(release_tog),
    .soft_tog_out(soft_tog)
  );

  // Bring DATA and the command toggles across
  logic [3:0] sync_in;
  logic [3:0] sync_out;

  assign sync_in = {soft_tog, release_tog, reset_tog, link_data_in};

  twtcc_sync #(
    .W(4)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_q),
    .d_in(sync_in),
    .q_out(sync_out)
  );

  // Edge detection on synchronised signals
  logic [3:0] prev_q, prev_d;
  logic data_s;
  logic data_rise;
  logic data_fall;
  logic reset_evt;
  logic release_evt;
  logic soft_evt;

  always_comb begin
    prev_d = sync_out;
  end

  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // One-cycle events from DATA edges and toggle changes
  assign data_s = sync_out[0];
  assign data_rise = sync_out[0] & ~prev_q[0];
  assign data_fall = ~sync_out[0] & prev_q[0];
  assign reset_evt = sync_out[1] ^ prev_q[1];
  assign release_evt = sync_out[2] ^ prev_q[2];
  assign soft_evt = sync_out[3] ^ prev_q[3];

  // Port enable: only the command stream changes it
  logic port_on_q, port_on_d;

  always_comb begin
    port_on_d = port_on_q;
    // Reset wins if both land in one cycle
    if (reset_evt) begin
      port_on_d = 1'b1;
    end else if (release_evt) begin
      port_on_d = 1'b0;
    end
  end

  // Starts enabled so stray DATA edges cannot fire
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      port_on_q <= 1'b1;
    end else begin
      port_on_q <= port_on_d;
    end
  end

  // Stop window length from the select code
  logic [SMW-1:0] stop_ms;
  logic [SMW-1:0] sel_idx;

  always_comb begin
    sel_idx = SMW'(stop_select_in[twtcc_pkg::STOP_COARSE_BIT-1:0]);
    if (stop_select_in[twtcc_pkg::STOP_COARSE_BIT]) begin
      stop_ms = twtcc_pkg::STOP_COARSE_BASE_MS +
        SMW'(sel_idx * twtcc_pkg::STOP_COARSE_STEP_MS);
    end else begin
      stop_ms = twtcc_pkg::STOP_FINE_BASE_MS +
        SMW'(sel_idx * twtcc_pkg::STOP_FINE_STEP_MS);
    end
  end

  // Core state, timers and outputs
  twtcc_pkg::twtcc_state_t state_q, state_d;
  logic [MSW-1:0] ms_cnt_q, ms_cnt_d;
  logic [SMW-1:0] low_ms_q, low_ms_d;
  logic [CLW-1:0] cal_cnt_q, cal_cnt_d;
  logic core_rst_q, core_rst_d;
  logic tx_data_q, tx_data_d;
  logic start_edge;
  logic stop_hit;

  // Trigger edge follows the configured start option
  assign start_edge = start_edge_select_in ? data_fall : data_rise;
  assign stop_hit = (low_ms_q >= stop_ms);

  // Next-state logic for the core sequencer
  always_comb begin
    state_d = state_q;
    ms_cnt_d = ms_cnt_q;
    low_ms_d = low_ms_q;
    cal_cnt_d = cal_cnt_q;
    core_rst_d = 1'b0;
    tx_data_d = 1'b0;
    if (soft_evt) begin
      // Soft reset clears everything but the port
      state_d = twtcc_pkg::ST_CAL;
      core_rst_d = 1'b1;
      cal_cnt_d = '0;
      ms_cnt_d = '0;
      low_ms_d = '0;
    end else begin
      case (state_q)
        twtcc_pkg::ST_SLEEP: begin
          ms_cnt_d = '0;
          low_ms_d = '0;
          // Blocked while the port is on
          if (!port_on_q && start_edge) begin
            state_d = twtcc_pkg::ST_TX;
          end
        end
        twtcc_pkg::ST_CAL: begin
          // Triggers are ignored until calibration ends
          if (cal_cnt_q == CAL_LAST) begin
            state_d = twtcc_pkg::ST_SLEEP;
            cal_cnt_d = '0;
          end else begin
            cal_cnt_d = cal_cnt_q + 1'b1;
          end
        end
        twtcc_pkg::ST_TX: begin
          tx_data_d = data_s;
          if (stop_hit) begin
            state_d = twtcc_pkg::ST_SLEEP;
            tx_data_d = 1'b0;
          end else if (data_s) begin
            // Any high level restarts the low window
            ms_cnt_d = '0;
            low_ms_d = '0;
          end else if (ms_cnt_q == MS_LAST) begin
            ms_cnt_d = '0;
            low_ms_d = low_ms_q + 1'b1;
          end else begin
            ms_cnt_d = ms_cnt_q + 1'b1;
          end
        end
        default: begin
          state_d = twtcc_pkg::ST_SLEEP;
          ms_cnt_d = '0;
          low_ms_d = '0;
          cal_cnt_d = '0;
        end
      endcase
    end
  end

  // Registers of the core sequencer
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      state_q <= twtcc_pkg::ST_SLEEP;
      ms_cnt_q <= '0;
      low_ms_q <= '0;
      cal_cnt_q <= '0;
      core_rst_q <= 1'b0;
      tx_data_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ms_cnt_q <= ms_cnt_d;
      low_ms_q <= low_ms_d;
      cal_cnt_q <= cal_cnt_d;
      core_rst_q <= core_rst_d;
      tx_data_q <= tx_data_d;
    end
  end

  // Outputs, state flags decoded from registers
  assign core_reset_out = core_rst_q;
  assign cal_busy_out = (state_q == twtcc_pkg::ST_CAL);
  assign tx_active_out = (state_q == twtcc_pkg::ST_TX);
  assign sleep_out = (state_q == twtcc_pkg::ST_SLEEP);
  assign two_wire_port_on_out = port_on_q;
  assign tx_data_out = tx_data_q;

  // Checks in the system domain
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_q);

  // Soft reset pulses core reset and enters calibration
  soft_cal_entry_a: assert property (
    soft_evt |=> core_rst_q && state_q == twtcc_pkg::ST_CAL
  ) else $error("soft reset did not start calibration");

  // Soft reset leaves the port state alone
  port_kept_a: assert property (
    soft_evt && !reset_evt && !release_evt |=>
      port_on_q == $past(port_on_q)
  ) else $error("soft reset disturbed the port state");

  // Release turns the port off
  release_off_a: assert property (
    release_evt && !reset_evt |=> !port_on_q
  ) else $error("release did not turn the port off");

  // Port reset turns it on and it stays on a while
  reset_on_a: assert property (
    reset_evt ##1 !release_evt [*2] |-> port_on_q [*2]
  ) else $error("port reset did not hold the port on");

  // No transmission start while the port is on
  no_trigger_a: assert property (
    state_q == twtcc_pkg::ST_SLEEP && port_on_q |=>
      state_q != twtcc_pkg::ST_TX
  ) else $error("transmission started while port on");

  // Calibration end brings sleep
  cal_sleep_a: assert property (
    state_q == twtcc_pkg::ST_CAL && cal_cnt_q == CAL_LAST && !soft_evt
      |=> state_q == twtcc_pkg::ST_SLEEP
  ) else $error("calibration end did not enter sleep");

  // Stop window reached ends transmission
  stop_sleep_a: assert property (
    state_q == twtcc_pkg::ST_TX && stop_hit && !soft_evt
      |=> state_q == twtcc_pkg::ST_SLEEP && !tx_data_q
  ) else $error("stop window did not end transmission");

  // Rising start: idle sleep, port off, DATA rises
  sequence rise_start_s;
    state_q == twtcc_pkg::ST_SLEEP && !port_on_q &&
      !start_edge_select_in && data_rise && !soft_evt;
  endsequence

  rise_start_a: assert property (
    rise_start_s |=> state_q == twtcc_pkg::ST_TX
  ) else $error("rising DATA edge did not start transmission");

  // Window length is in range for both scales
  window_range_a: assert property (
    stop_ms >= twtcc_pkg::STOP_FINE_BASE_MS &&
      stop_ms <= twtcc_pkg::STOP_COARSE_BASE_MS +
        7 * twtcc_pkg::STOP_COARSE_STEP_MS
  ) else $error("stop window out of range");

endmodule : twtcc_top

// ---- src/twtcc_pkg.sv ----
// Constants for the two-wire transmit command control block
package twtcc_pkg;

  // Command framing
  localparam int CMD_W = 16;
  localparam int RST_LOW_BITS = 32;
  localparam int RST_TOTAL_BITS = CMD_W + RST_LOW_BITS;
  localparam int BIT_CNT_W = 6;
  localparam logic [CMD_W-1:0] CMD_IFACE_RESET = 16'h8D00;
  localparam logic [CMD_W-1:0] CMD_IFACE_RELEASE = 16'h8D02;
  localparam logic [CMD_W-1:0] CMD_SOFT_RESET = 16'hBD01;

  // Clock rate and time units
  localparam int CLK_MHZ = 100;
  localparam int US_PER_MS = 1000;
  localparam int TICK_TIME_MS = 1;
  localparam int CAL_TIME_US = 500;
  localparam int MS_CNT_W = 20;
  localparam int CAL_CNT_W = 20;

  // Stop window selection, in ms
  localparam int STOP_SEL_W = 4;
  localparam int STOP_MS_W = 7;
  localparam int STOP_COARSE_BIT = 3;
  localparam logic [STOP_MS_W-1:0] STOP_FINE_BASE_MS = 7'h02;
  localparam logic [STOP_MS_W-1:0] STOP_FINE_STEP_MS = 7'h01;
  localparam logic [STOP_MS_W-1:0] STOP_COARSE_BASE_MS = 7'h14;
  localparam logic [STOP_MS_W-1:0] STOP_COARSE_STEP_MS = 7'h0A;

  // Core states
  typedef enum logic [1:0] {
    ST_SLEEP = 2'h0,
    ST_CAL = 2'h1,
    ST_TX = 2'h2
  } twtcc_state_t;

endpackage : twtcc_pkg

// ---- src/twtcc_sync.sv ----
// Two-stage synchroniser for a group of level signals
`timescale 1ns/1ps
module twtcc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Levels from a foreign domain
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule : twtcc_sync

// ---- src/twtcc_shifter.sv ----
// Link-clock command shifter and decoder for the two-wire port
`timescale 1ns/1ps
module twtcc_shifter (
  // Link clock and reset
  input wire logic link_clk_in,
  input wire logic rst_n_in,
  // Serial data from host
  input wire logic data_in,
  // Command event toggles
  output logic reset_tog_out,
  output logic release_tog_out,
  output logic soft_tog_out
);

  localparam int BW = twtcc_pkg::BIT_CNT_W;
  localparam int SW = twtcc_pkg::RST_TOTAL_BITS;
  localparam int CW = twtcc_pkg::CMD_W;
  localparam logic [BW-1:0] CNT_FULL = BW'(twtcc_pkg::RST_TOTAL_BITS);
  localparam logic [BW-1:0] CNT_WORD = BW'(twtcc_pkg::CMD_W);

  logic [SW-1:0] sr_q, sr_d;
  logic [BW-1:0] cnt_q, cnt_d;
  logic reset_tog_q, reset_tog_d;
  logic release_tog_q, release_tog_d;
  logic soft_tog_q, soft_tog_d;
  logic [BW-1:0] cnt_inc;

  // Shift MSB first, count bits since last command
  always_comb begin
    sr_d = {sr_q[SW-2:0], data_in};
    cnt_inc = (cnt_q == CNT_FULL) ? cnt_q : cnt_q + 1'b1;
    cnt_d = cnt_inc;
    reset_tog_d = reset_tog_q;
    release_tog_d = release_tog_q;
    soft_tog_d = soft_tog_q;
    // Reset needs all 48 bits: 32 low then pattern
    if (cnt_inc == CNT_FULL &&
        sr_d[SW-1:CW] == '0 &&
        sr_d[CW-1:0] == twtcc_pkg::CMD_IFACE_RESET) begin
      reset_tog_d = ~reset_tog_q;
      cnt_d = '0;
    end else if (cnt_inc >= CNT_WORD &&
        sr_d[CW-1:0] == twtcc_pkg::CMD_IFACE_RELEASE) begin
      release_tog_d = ~release_tog_q;
      cnt_d = '0;
    end else if (cnt_inc >= CNT_WORD &&
        sr_d[CW-1:0] == twtcc_pkg::CMD_SOFT_RESET) begin
      soft_tog_d = ~soft_tog_q;
      cnt_d = '0;
    end
    // Any other pattern just keeps shifting
  end

  // Data is captured on the falling link edge
  always_ff @(negedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sr_q <= '0;
      cnt_q <= '0;
      reset_tog_q <= 1'b0;
      release_tog_q <= 1'b0;
      soft_tog_q <= 1'b0;
    end else begin
      sr_q <= sr_d;
      cnt_q <= cnt_d;
      reset_tog_q <= reset_tog_d;
      release_tog_q <= release_tog_d;
      soft_tog_q <= soft_tog_d;
    end
  end

  assign reset_tog_out = reset_tog_q;
  assign release_tog_out = release_tog_q;
  assign soft_tog_out = soft_tog_q;

  // Reset seen only after 32 low bits and its pattern
  reset_frame_a: assert property (
    @(negedge link_clk_in) disable iff (!rst_n_in)
    $changed(reset_tog_q) |->
      sr_q[SW-1:CW] == '0 && sr_q[CW-1:0] == twtcc_pkg::CMD_IFACE_RESET
  ) else $error("port reset without full frame");

  // Release and soft reset need a whole word
  word_length_a: assert property (
    @(negedge link_clk_in) disable iff (!rst_n_in)
    ($changed(release_tog_q) || $changed(soft_tog_q)) |->
      $past(cnt_q) >= CNT_WORD - 1'b1
  ) else $error("command word shorter than 16 bits");

endmodule : twtcc_shifter

// ---- test/twtcc_host.sv ----
// Host model driving the two-wire link clock and data
`timescale 1ns/1ps
module twtcc_host (
  // Link pins towards the device
  output logic link_clk_out,
  output logic link_data_out
);
  // Clock rests high between frames and through transmission
  initial begin
    link_clk_out = 1'b1;
    link_data_out = 1'b0;
  end

  // Shift n bits MSB first; the lead-in keeps the first fall late enough
  task automatic send_bits(input logic [47:0] bits, input int n);
    link_data_out = bits[n-1];
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      link_data_out = bits[i];
      #7.5 link_clk_out = 1'b0;
      #7.5 link_clk_out = 1'b1;
    end
  endtask : send_bits

  // Payload level outside frames, clock stays high
  task automatic set_level(input logic v);
    link_data_out = v;
  endtask : set_level
endmodule : twtcc_host

// ---- test/twtcc_tb.sv ----
// Self-checking bench for the two-wire command control block
`timescale 1ns/1ps
module tb;
  localparam int MS = 20;
  localparam int CAL = 10;
  logic clk_in, reset_n_in, link_clk, link_data, edge_sel;
  logic [twtcc_pkg::STOP_SEL_W-1:0] stop_sel;
  logic core_rst, cal_busy, tx_act, sleep, port_on, tx_data;
  logic [3:0] exp_q[$];
  logic [3:0] prev_st;
  int bad_count, checks_done, cycles, soft_seen, soft_sent;
  wire [3:0] st = {cal_busy, tx_act, sleep, port_on};

  // Short timers keep the run small; every pin is driven or watched
  twtcc_top #(
    .MS_CYCLES(MS),
    .CAL_CYCLES(CAL)
  ) twtcc_top_i (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .link_clk_in(link_clk),
    .link_data_in(link_data),
    .start_edge_select_in(edge_sel),
    .stop_select_in(stop_sel),
    .core_reset_out(core_rst),
    .cal_busy_out(cal_busy),
    .tx_active_out(tx_act),
    .sleep_out(sleep),
    .two_wire_port_on_out(port_on),
    .tx_data_out(tx_data)
  );

  // Host model owns the link clock and data pins
  twtcc_host twtcc_host_i (
    .link_clk_out(link_clk),
    .link_data_out(link_data)
  );

  // System clock, 100 MHz
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // Every state change must match the oldest note; none is unexpected
  always @(negedge clk_in) begin
    if (reset_n_in && st !== prev_st) begin
      if (exp_q.size() == 0) chk(st, prev_st);
      else chk(st, exp_q.pop_front());
      prev_st = st;
    end
    if (core_rst === 1'b1) soft_seen++;
    cycles++;
    if (cycles > 40000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc

  task automatic wait_st(input logic [3:0] s, input int lim, output int k);
    k = 0;
    while (st !== s && k < lim) begin
      @(negedge clk_in);
      k++;
    end
  endtask : wait_st

  // Frames start 2 ns after a falling system clock edge
  task automatic cmd(input logic [47:0] w, input int n);
    #2;
    twtcc_host_i.send_bits(w, n);
    cyc(8);
  endtask : cmd

  // Port reset then core soft reset, the usual end of a payload
  task automatic finish(input bit trig);
    if (trig) exp_q.push_back(4'h4);
    exp_q.push_back(4'h5);
    exp_q.push_back(4'h9);
    exp_q.push_back(4'h3);
    cmd({32'h0, 16'h8D00}, 48);
    cmd(48'hBD01, 16);
    soft_sent++;
    cyc(CAL + MS);
  endtask : finish

  // One transmission; kind 0 ends by stop window, 1 by commands, 2 by soft
  task automatic run(input bit mode, input int kind);
    int k;
    int ms;
    logic [3:0] sel;
    sel = 4'($urandom);
    if (kind == 1) sel[3] = 1'b1;
    ms = sel[3] ? 20 + 10 * sel[2:0] : 2 + sel[2:0];
    edge_sel = mode;
    stop_sel = sel;
    exp_q.push_back(4'h2);
    cmd(48'h8D02, 16);
    if (mode) begin
      twtcc_host_i.set_level(1'b1);
      cyc(10);
    end
    exp_q.push_back(4'h4);
    twtcc_host_i.set_level(!mode);
    wait_st(4'h4, 20, k);
    twtcc_host_i.set_level(1'b1);
    cyc(6);
    chk(tx_data, 1'b1);
    twtcc_host_i.set_level(1'b0);
    if (kind == 0) begin
      exp_q.push_back(4'h2);
      wait_st(4'h2, 2000, k);
      chk(k >= ms * MS && k <= ms * MS + 6, 1'b1);
      chk(tx_data, 1'b0);
      finish(1'b1);
    end else if (kind == 1) begin
      finish(1'b0);
    end else begin
      exp_q.push_back(4'h8);
      exp_q.push_back(4'h2);
      cmd(48'hBD01, 16);
      soft_sent++;
      cyc(CAL + MS);
      finish(1'b1);
    end
  endtask : run

  initial begin
    reset_n_in = 1'b0;
    edge_sel = 1'b0;
    stop_sel = '0;
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    soft_seen = 0;
    soft_sent = 0;
    prev_st = 4'h3;
    void'($urandom(9107));
    cyc(4);
    reset_n_in = 1'b1;
    cyc(4);
    chk(st, 4'h3);
    chk(tx_data, 1'b0);
    // Near miss word and a trigger edge, both to be ignored
    cmd(48'h8D03, 16);
    twtcc_host_i.set_level(1'b1);
    cyc(10);
    twtcc_host_i.set_level(1'b0);
    cyc(10);
    exp_q.push_back(4'h9);
    exp_q.push_back(4'h3);
    cmd(48'hBD01, 16);
    soft_sent++;
    cyc(CAL + MS);
    for (int i = 0; i < 6; i++) begin
      run(i % 2, i / 2);
    end
    chk(exp_q.size(), 0);
    chk(soft_seen, soft_sent);
    end_sim();
  end
endmodule : tb
